// ### hw/rdc_chain.v
// Resampler, fifth-order decimator and coefficient filter chain
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - Resampler decimation minus one, 12 bits
// - Resampler interpolation minus one, 9 bits
// - Strong-signal scale bits 4-0
// - Weak-signal scale bits 9-5
// - Bit 10 picks 6 or 12 dB steps
// - Bit 11 inverts external exponent
// - Ratio 1/1 bypasses the resampler sections only
// - Fifth-order decimation 2 to 32
// - Five cascaded sections, gain M^5/2^(S+5)
// - Fifth-order scale 0..20, 6 dB each
// - One output per M inputs
// - Fifth-order input up to full rate
// - Resampler takes samples every clock
// - 160 complex 20-bit data words kept
// - 256 coefficients of 20 bits
// - One I and Q tap per clock
// - Filter output 24 bits wide
// - Input scaled by 2^-((exp+scale) mod 32)
`include "rdc_defs.vh"
module rdc_chain (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Complex input samples
  input wire in_valid_i,
  input wire [13:0] in_i_i,
  input wire [13:0] in_q_i,
  input wire [2:0] exp_i,
  input wire strong_i,
  // Filtered output samples
  output wire out_valid_o,
  output wire [23:0] out_i_o,
  output wire [23:0] out_q_o
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  // Ring index add, sum below 320
  function [7:0] ring_add;
    input [7:0] a;
    input [8:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + b;
      if (s >= {1'b0, `RDC_DEPTH})
        s = s - {1'b0, `RDC_DEPTH};
      ring_add = s[7:0];
    end
  endfunction

  // Scale a 14-bit input into 20 bits by a right shift
  function [47:0] scale_in;
    input [13:0] x;
    input [4:0] sh;
    reg signed [47:0] w;
    begin
      w = {{28{x[13]}}, x, `RDC_IN_PAD};
      scale_in = w >>> sh;
    end
  endfunction

  // ==========================================
  // Registers
  reg [11:0] rdec_reg; // Decimation minus one
  reg [8:0] rint_reg; // Interpolation minus one
  reg [11:0] rscl_reg; // Scale control
  reg [10:0] c5_reg; // Fifth-order ratio and scale
  reg [7:0] taps_reg; // Tap count minus one
  reg [7:0] cadr_reg; // Coefficient write pointer
  reg [15:0] ocnt_reg; // Output sample count
  reg [1:0] st_reg; // Engine state
  wire busy = st_reg[1]; // Filter computing
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg [19:0] coef_mem [0:255]; // Coefficients
  reg [19:0] dmem_i [0:159]; // In-phase history
  reg [19:0] dmem_q [0:159]; // Quadrature history
  wire [9:0] idx = paddr_i[11:2]; // Word index
  wire acc_ph = psel_i & penable_i & ~pready_reg;
  wire wr_en = acc_ph & pwrite_i;
  reg hit; // Address mapped
  reg [31:0] rd_next;

  // Read mux and decode
  always @* begin
    hit = 1'b1;
    rd_next = 32'h0;
    case (idx)
      `RDC_IDX_RDEC: rd_next = {20'h0, rdec_reg};
      `RDC_IDX_RINT: rd_next = {23'h0, rint_reg};
      `RDC_IDX_RSCL: rd_next = {20'h0, rscl_reg};
      `RDC_IDX_C5: rd_next = {21'h0, c5_reg};
      `RDC_IDX_TAPS: rd_next = {24'h0, taps_reg};
      `RDC_IDX_CADR: rd_next = {24'h0, cadr_reg};
      `RDC_IDX_CDAT: rd_next = 32'h0;
      `RDC_IDX_STAT: rd_next = {15'h0, busy, ocnt_reg};
      default: hit = 1'b0;
    endcase
  end

  // Bus answer: one wait state, then ready
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= acc_ph;
      pslverr_reg <= acc_ph & ~hit;
      if (acc_ph & ~pwrite_i)
        prdata_reg <= rd_next;
    end
  end

  // Register writes; taken on the same edge that raises ready
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdec_reg <= 12'h0;
      rint_reg <= 9'h0;
      rscl_reg <= 12'h0;
      c5_reg <= `RDC_C5_RST;
      taps_reg <= 8'h0;
      cadr_reg <= 8'h0;
    end else if (wr_en) begin
      case (idx)
        `RDC_IDX_RDEC: rdec_reg <= pwdata_i[11:0];
        `RDC_IDX_RINT: rint_reg <= pwdata_i[8:0];
        `RDC_IDX_RSCL: rscl_reg <= pwdata_i[11:0];
        `RDC_IDX_C5: c5_reg <= pwdata_i[10:0];
        `RDC_IDX_TAPS: taps_reg <= pwdata_i[7:0];
        `RDC_IDX_CADR: cadr_reg <= pwdata_i[7:0];
        `RDC_IDX_CDAT: cadr_reg <= cadr_reg + 8'h01;
        default: cadr_reg <= cadr_reg;
      endcase
    end
  end

  // Coefficient memory write port
  always @(posedge clk_i) begin
    if (wr_en && idx == `RDC_IDX_CDAT)
      coef_mem[cadr_reg] <= pwdata_i[19:0];
  end

  // ==========================================
  // Input gain scaling
  wire [4:0] sel_scl = strong_i ?
    rscl_reg[`RDC_STRONG_HI:`RDC_STRONG_LO] :
    rscl_reg[`RDC_WEAK_HI:`RDC_WEAK_LO];
  wire [2:0] exp_eff = rscl_reg[`RDC_EXPONENT_INVERT_BIT] ?
    (`RDC_EXP_TOP - exp_i) : exp_i;
  wire [4:0] exp_stp = rscl_reg[`RDC_STEP12_BIT] ?
    {1'b0, exp_eff, 1'b0} : {2'b0, exp_eff};
  wire [4:0] shift = exp_stp + sel_scl; // Wraps mod 32
  wire [47:0] xi = scale_in(in_i_i, shift);
  wire [47:0] xq = scale_in(in_q_i, shift);

  // ==========================================
  // Resampling second-order stage
  reg [12:0] lact_reg; // Active interpolation
  reg [12:0] mact_reg; // Active decimation
  reg [12:0] ph_reg; // Phase accumulator
  reg [47:0] ri1_reg, ri2_reg, rq1_reg, rq2_reg;
  reg [47:0] rci1_reg, rci2_reg, rcq1_reg, rcq2_reg;
  reg [19:0] rs_i_reg, rs_q_reg; // Stage output
  reg rs_v_reg;
  wire bypass = (lact_reg == mact_reg);
  wire [12:0] ph_sum = ph_reg + lact_reg;
  wire r_fire = in_valid_i & (bypass | (ph_sum >= mact_reg));
  wire [47:0] ni1 = ri1_reg + xi;
  wire [47:0] ni2 = ri2_reg + ni1;
  wire [47:0] nq1 = rq1_reg + xq;
  wire [47:0] nq2 = rq2_reg + nq1;
  wire [47:0] ci1 = ni2 - rci1_reg;
  wire [47:0] cq1 = nq2 - rcq1_reg;

  // Integrate every sample, comb on each output
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lact_reg <= 13'h1;
      mact_reg <= 13'h1;
      ph_reg <= 13'h0;
      {ri1_reg, ri2_reg, rq1_reg, rq2_reg} <= 192'h0;
      {rci1_reg, rci2_reg, rcq1_reg, rcq2_reg} <= 192'h0;
      rs_i_reg <= 20'h0;
      rs_q_reg <= 20'h0;
      rs_v_reg <= 1'b0;
    end else begin
      rs_v_reg <= r_fire; // Accepts a sample each clock
      if (in_valid_i) begin
        ri1_reg <= ni1;
        ri2_reg <= ni2;
        rq1_reg <= nq1;
        rq2_reg <= nq2;
        ph_reg <= r_fire ? (bypass ? 13'h0 : ph_sum - mact_reg) : ph_sum;
      end
      if (r_fire) begin
        // Settings change only between outputs
        lact_reg <= {4'h0, rint_reg} + 13'h1;
        mact_reg <= {1'b0, rdec_reg} + 13'h1;
        rci1_reg <= ni2;
        rci2_reg <= ci1;
        rcq1_reg <= nq2;
        rcq2_reg <= cq1;
        rs_i_reg <= bypass ? xi[19:0] : ci1[19:0] - rci2_reg[19:0];
        rs_q_reg <= bypass ? xq[19:0] : cq1[19:0] - rcq2_reg[19:0];
      end
    end
  end

  // ==========================================
  // Fifth-order decimating stage
  reg [47:0] ii_reg [0:4]; // I integrators
  reg [47:0] iq_reg [0:4]; // Q integrators
  reg [47:0] di_reg [0:4]; // I comb delays
  reg [47:0] dq_reg [0:4]; // Q comb delays
  reg [5:0] c5m_reg; // Active ratio
  reg [4:0] c5s_reg; // Active scale
  reg [5:0] c5cnt_reg; // Input counter
  reg [19:0] c5_i_reg, c5_q_reg;
  reg c5_v_reg;
  reg [47:0] ii_n [0:4];
  reg [47:0] iq_n [0:4];
  reg [47:0] ci_n [0:5];
  reg [47:0] cq_n [0:5];
  reg [5:0] sh5;
  reg [47:0] c5i_sh, c5q_sh; // Scaled comb outputs, full width
  integer k;
  integer j; // Loop index of the combinational cascade
  wire [5:0] m_raw = c5_reg[`RDC_C5M_HI:`RDC_C5M_LO];
  wire [4:0] s_raw = c5_reg[`RDC_C5S_HI:`RDC_C5S_LO];
  wire c5_last = (c5cnt_reg == c5m_reg - 6'h01);
  wire c5_fire = rs_v_reg & c5_last;

  // Cascade of five integrators and five combs
  always @* begin
    ii_n[0] = ii_reg[0] + {{28{rs_i_reg[19]}}, rs_i_reg};
    iq_n[0] = iq_reg[0] + {{28{rs_q_reg[19]}}, rs_q_reg};
    for (j = 1; j < 5; j = j + 1) begin
      ii_n[j] = ii_reg[j] + ii_n[j-1];
      iq_n[j] = iq_reg[j] + iq_n[j-1];
    end
    ci_n[0] = ii_n[4];
    cq_n[0] = iq_n[4];
    for (j = 0; j < 5; j = j + 1) begin
      ci_n[j+1] = ci_n[j] - di_reg[j];
      cq_n[j+1] = cq_n[j] - dq_reg[j];
    end
    sh5 = {1'b0, c5s_reg} + `RDC_C5S_EXTRA; // 2^-(S+5)
    // Arithmetic shift keeps the sign; the low 20 bits are kept below
    c5i_sh = $signed(ci_n[5]) >>> sh5;
    c5q_sh = $signed(cq_n[5]) >>> sh5;
  end

  // Count M inputs per output
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (k = 0; k < 5; k = k + 1) begin
        ii_reg[k] <= 48'h0;
        iq_reg[k] <= 48'h0;
        di_reg[k] <= 48'h0;
        dq_reg[k] <= 48'h0;
      end
      c5m_reg <= `RDC_C5M_MIN;
      c5s_reg <= 5'h0;
      c5cnt_reg <= 6'h0;
      c5_i_reg <= 20'h0;
      c5_q_reg <= 20'h0;
      c5_v_reg <= 1'b0;
    end else begin
      c5_v_reg <= c5_fire;
      if (rs_v_reg) begin // Full-rate input
        for (k = 0; k < 5; k = k + 1) begin
          ii_reg[k] <= ii_n[k];
          iq_reg[k] <= iq_n[k];
        end
        c5cnt_reg <= c5_last ? 6'h0 : c5cnt_reg + 6'h01;
      end
      if (c5_fire) begin
        for (k = 0; k < 5; k = k + 1) begin
          di_reg[k] <= ci_n[k];
          dq_reg[k] <= cq_n[k];
        end
        c5_i_reg <= c5i_sh[19:0];
        c5_q_reg <= c5q_sh[19:0];
        // Ratio and scale clamped, loaded at boundary
        c5m_reg <= (m_raw < `RDC_C5M_MIN) ? `RDC_C5M_MIN :
          (m_raw > `RDC_C5M_MAX) ? `RDC_C5M_MAX : m_raw;
        c5s_reg <= (s_raw > `RDC_C5S_MAX) ? `RDC_C5S_MAX : s_raw;
      end
    end
  end

  // ==========================================
  // Coefficient filter
  reg [7:0] wp_reg; // Newest data slot
  reg [7:0] rp_reg; // Data read slot
  reg [7:0] cp_reg; // Coefficient slot
  reg [7:0] kc_reg; // Taps left minus one
  reg signed [47:0] acc_i_reg, acc_q_reg;
  reg [23:0] oi_reg, oq_reg;
  reg ov_reg;
  wire [7:0] ntaps = (taps_reg >= `RDC_DEPTH - 8'h01) ?
    `RDC_DEPTH : taps_reg + 8'h01;
  wire [7:0] wp_new = ring_add(wp_reg, 9'h001);
  wire signed [39:0] pi = $signed(dmem_i[rp_reg]) * $signed(coef_mem[cp_reg]);
  wire signed [39:0] pq = $signed(dmem_q[rp_reg]) * $signed(coef_mem[cp_reg]);
  wire signed [47:0] si = acc_i_reg + {{8{pi[39]}}, pi};
  wire signed [47:0] sq = acc_q_reg + {{8{pq[39]}}, pq};

  // Circular data history
  always @(posedge clk_i) begin
    if (c5_v_reg) begin
      dmem_i[wp_new] <= c5_i_reg;
      dmem_q[wp_new] <= c5_q_reg;
    end
  end

  // Oldest to newest, one I and Q tap per clock
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= ST_IDLE;
      wp_reg <= 8'h0;
      rp_reg <= 8'h0;
      cp_reg <= 8'h0;
      kc_reg <= 8'h0;
      acc_i_reg <= 48'h0;
      acc_q_reg <= 48'h0;
      oi_reg <= 24'h0;
      oq_reg <= 24'h0;
      ov_reg <= 1'b0;
      ocnt_reg <= 16'h0;
    end else begin
      ov_reg <= 1'b0;
      if (c5_v_reg)
        wp_reg <= wp_new;
      case (st_reg)
        ST_IDLE: begin
          if (c5_v_reg) begin
            st_reg <= ST_RUN;
            rp_reg <= ring_add(wp_new, {1'b0, `RDC_DEPTH - ntaps} + 9'h001);
            cp_reg <= 8'h0;
            kc_reg <= ntaps - 8'h01;
            acc_i_reg <= 48'h0;
            acc_q_reg <= 48'h0;
          end
        end
        ST_RUN: begin
          acc_i_reg <= si;
          acc_q_reg <= sq;
          rp_reg <= ring_add(rp_reg, 9'h001);
          cp_reg <= cp_reg + 8'h01;
          kc_reg <= kc_reg - 8'h01;
          if (kc_reg == 8'h0) begin
            st_reg <= ST_IDLE;
            oi_reg <= si[`RDC_OUT_LSB+23:`RDC_OUT_LSB];
            oq_reg <= sq[`RDC_OUT_LSB+23:`RDC_OUT_LSB];
            ov_reg <= 1'b1;
            ocnt_reg <= ocnt_reg + 16'h0001;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Outputs
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign out_valid_o = ov_reg;
  assign out_i_o = oi_reg;
  assign out_q_o = oq_reg;
endmodule // rdc_chain

// ### hw/rdc_defs.vh
// Constants for the receive decimation chain
`ifndef RDC_DEFS_VH
`define RDC_DEFS_VH
// ==========================================
// Register indexes (byte address = 4 x index)
`define RDC_IDX_RDEC 10'h090
`define RDC_IDX_RINT 10'h091
`define RDC_IDX_RSCL 10'h092
`define RDC_IDX_C5 10'h093
`define RDC_IDX_TAPS 10'h094
`define RDC_IDX_CADR 10'h095
`define RDC_IDX_CDAT 10'h096
`define RDC_IDX_STAT 10'h097
// ==========================================
// Scale register fields
`define RDC_STRONG_HI 4
`define RDC_STRONG_LO 0
`define RDC_WEAK_HI 9
`define RDC_WEAK_LO 5
`define RDC_STEP12_BIT 10
`define RDC_EXPONENT_INVERT_BIT 11
// Fifth-order control fields
`define RDC_C5M_HI 5
`define RDC_C5M_LO 0
`define RDC_C5S_HI 10
`define RDC_C5S_LO 6
// ==========================================
// Limits and reset values
`define RDC_C5M_MIN 6'h02
`define RDC_C5M_MAX 6'h20
`define RDC_C5S_MAX 5'h14
`define RDC_C5S_EXTRA 6'h05
`define RDC_EXP_TOP 3'h7
`define RDC_DEPTH 8'ha0
`define RDC_C5_RST 11'h002
`define RDC_OUT_LSB 16
`define RDC_IN_PAD 6'h00
`endif

// ### test/rdc_chain_monitor.sv
// Port checker for the decimation chain
`timescale 1ns/1ps
`include "rdc_defs.vh"
module rdc_chain_monitor (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Register bus
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Sample stream
  input wire in_valid_i,
  input wire out_valid_o,
  input wire [23:0] out_i_o,
  input wire [23:0] out_q_o
);
  // ==========================================
  // Cycles since the last input sample
  logic [7:0] idle_reg;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_reg <= 8'h00;
    end else if (in_valid_i) begin
      idle_reg <= 8'h00;
    end else if (idle_reg != 8'hff) begin
      idle_reg <= idle_reg + 8'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // Bus answers
  AST_RDY_ONE: assert property (pready_o |=> !pready_o) else $error("ready too long");
  AST_RDY_ANS: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no answer");
  AST_RDY_WHY: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  AST_ERR_RDY: assert property (pslverr_o |-> pready_o) else $error("lone error");
  AST_ERR_ZERO: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_DEC_W: assert property (
    pready_o && !pwrite_i && paddr_i[11:2] == `RDC_IDX_RDEC |-> prdata_o[31:12] == 20'h0)
    else $error("decimation too wide");
  AST_INT_W: assert property (
    pready_o && !pwrite_i && paddr_i[11:2] == `RDC_IDX_RINT |-> prdata_o[31:9] == 23'h0)
    else $error("interpolation too wide");
  AST_DATA_HOLD: assert property (!pready_o |-> $stable(prdata_o)) else $error("read data moved");
  // ==========================================
  // Filter results
  AST_OUT_PULSE: assert property (out_valid_o |=> !out_valid_o)
    else $error("valid too long");
  AST_OUT_HOLD: assert property (!out_valid_o |-> $stable({out_i_o, out_q_o}))
    else $error("result moved");
  AST_OUT_WHY: assert property (out_valid_o |-> idle_reg < 8'hb4)
    else $error("result without input");
endmodule // rdc_chain_monitor

bind rdc_chain rdc_chain_monitor MON (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .in_valid_i(in_valid_i),
  .out_valid_o(out_valid_o), .out_i_o(out_i_o), .out_q_o(out_q_o));

// ### test/rdc_source.sv
// Upstream sample source model
`timescale 1ns/1ps
module rdc_source (
  // Clock
  input wire clk_i,
  // Sample stream
  output logic valid_o,
  output logic [13:0] i_o,
  output logic [13:0] q_o,
  output logic [2:0] exp_o,
  output logic strong_o
);
  // ==========================================
  // Idle stream at time zero
  initial begin
    valid_o = 1'b0;
    i_o = 14'h0000;
    q_o = 14'h0000;
    exp_o = 3'h0;
    strong_o = 1'b0;
  end
  // One sample every second clock, lines inverted between samples
  task send(input int n, input logic [13:0] vi, input logic [13:0] vq,
            input logic [2:0] e, input logic s);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      valid_o <= 1'b1;
      i_o <= vi;
      q_o <= vq;
      exp_o <= e;
      strong_o <= s;
      @(posedge clk_i);
      valid_o <= 1'b0;
      i_o <= ~vi;
      q_o <= ~vq;
      exp_o <= ~e;
      strong_o <= ~s;
    end
  endtask
endmodule // rdc_source

// ### test/rdc_chain_bench.sv
// Self-checking bench for the decimation chain
`timescale 1ns/1ps
`include "rdc_defs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module rdc_chain_bench;
  // ==========================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, rd;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, in_valid_i, strong_i, out_valid_o;
  wire [13:0] in_i_i, in_q_i;
  wire [2:0] exp_i;
  wire [23:0] out_i_o, out_q_o;
  logic er, chk_on = 1'b0;
  logic [23:0] want_i, want_q;
  logic [11:0] sc;
  logic [13:0] v, q;
  logic [2:0] e;
  int failures = 0, n_tests = 0, n_out = 0, seed, a;
  int lr[5] = '{1, 2, 1, 1, 1}, mr[5] = '{1, 2, 2, 4, 1}, m5[5] = '{2, 3, 2, 4, 32};
  always #2 clk_i = ~clk_i;
  // ==========================================
  // Design and upstream model
  rdc_chain DUT (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .in_valid_i(in_valid_i), .in_i_i(in_i_i),
    .in_q_i(in_q_i), .exp_i(exp_i), .strong_i(strong_i), .out_valid_o(out_valid_o),
    .out_i_o(out_i_o), .out_q_o(out_q_o));
  rdc_source SRC (.clk_i(clk_i), .valid_o(in_valid_i), .i_o(in_i_i), .q_o(in_q_i),
    .exp_o(exp_i), .strong_o(strong_i));
  // One bus transfer, waits for ready
  task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int t;
    t = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 50);
    rd = prdata_o;
    er = pslverr_o;
    if (t >= 50) failures++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Scaled sample at unity chain gain
  function automatic logic [23:0] model(logic [13:0] x, logic [2:0] ex, logic s, logic [11:0] c);
    int sh;
    int d;
    sh = (c[11] ? 7 - ex : ex) * (c[10] ? 2 : 1);
    sh = (sh + (s ? c[4:0] : c[9:5])) % 32;
    d = ($signed(x) * 64) >>> sh;
    return d[23:0];
  endfunction
  // Count every filter result, compare those while chk_on is set
  always @(posedge clk_i) begin
    if (out_valid_o === 1'b1) begin
      n_out++;
      if (chk_on) begin
        `CHK(out_i_o, want_i)
        `CHK(out_q_o, want_q)
      end
    end
  end
  // Verdict and end of run
  task final_report;
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    failures++;
    final_report;
  end
  // ==========================================
  // Main sequence
  initial begin
    seed = $urandom(22);
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    for (int k = 0; k < 3; k++) begin // Reset value and width of the decimation, interpolation and scale controls
      apb(0, 10'(`RDC_IDX_RDEC + k), 32'h0);
      `CHK(rd, 32'h0)
      apb(1, 10'(`RDC_IDX_RDEC + k), 32'hffffffff);
      apb(0, 10'(`RDC_IDX_RDEC + k), 32'h0);
      `CHK(rd, (k == 1) ? 32'h1ff : 32'hfff)
    end
    apb(1, 10'h0a0, 32'hffffffff);
    `CHK(er, 1'b1)
    apb(0, 10'h0a0, 32'h0);
    `CHK(rd, 32'h0)
    apb(1, `RDC_IDX_RDEC, 32'h0);
    apb(1, `RDC_IDX_RINT, 32'h0);
    apb(1, `RDC_IDX_CADR, 32'h0);
    apb(1, `RDC_IDX_CDAT, 32'h00010000);
    apb(1, `RDC_IDX_TAPS, 32'h0);
    for (int k = 0; k < 16; k++) begin // Scaling modes in bypass
      sc = 12'($urandom);
      sc[11:10] = k[1:0];
      v = 14'($urandom);
      q = 14'($urandom);
      e = 3'($urandom);
      apb(1, `RDC_IDX_RSCL, {20'h0, sc});
      apb(1, `RDC_IDX_C5, k[3] ? 32'h00000144 : 32'h00000002);
      SRC.send(48, v, q, e, k[2]);
      want_i = model(v, e, k[2], sc);
      want_q = model(q, e, k[2], sc);
      chk_on = 1'b1;
      SRC.send(16, v, q, e, k[2]);
      repeat (20) @(posedge clk_i);
      chk_on = 1'b0;
    end
    for (int k = 0; k < 5; k++) begin // Output count per rate setting
      apb(1, `RDC_IDX_RDEC, mr[k] - 1);
      apb(1, `RDC_IDX_RINT, lr[k] - 1);
      apb(1, `RDC_IDX_C5, m5[k]);
      SRC.send(64, 14'($urandom), 14'($urandom), 3'h0, 1'b1);
      repeat (20) @(posedge clk_i);
      a = n_out;
      SRC.send(mr[k] / lr[k] * m5[k] * 4, 14'($urandom), 14'($urandom), 3'h0, 1'b1);
      repeat (20) @(posedge clk_i);
      `CHK(n_out - a, 4)
    end
    // Three-tap filter with gains 1, 2 and 4 on a steady input
    apb(1, `RDC_IDX_RSCL, 32'h0);
    apb(1, `RDC_IDX_C5, 32'h00000002);
    apb(1, `RDC_IDX_CADR, 32'h0);
    for (int j = 0; j < 3; j++) begin
      apb(1, `RDC_IDX_CDAT, 32'h00010000 << j);
    end
    apb(1, `RDC_IDX_TAPS, 32'h2);
    v = 14'($urandom);
    q = 14'($urandom);
    SRC.send(64, v, q, 3'h0, 1'b1);
    want_i = 24'($signed(v) * 448);
    want_q = 24'($signed(q) * 448);
    chk_on = 1'b1;
    SRC.send(16, v, q, 3'h0, 1'b1);
    repeat (20) @(posedge clk_i);
    chk_on = 1'b0;
    // Pointer after three coefficient writes, then the result count
    apb(0, `RDC_IDX_CADR, 32'h0);
    `CHK(rd, 32'h3)
    apb(0, `RDC_IDX_STAT, 32'h0);
    `CHK(rd, {16'h0, 16'(n_out)})
    final_report;
  end
endmodule // rdc_chain_bench
